// ==== design/lcd_segment_driver_regs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the LCD segment driver.
// Assumes: Display memory sits at page 3 offsets 00h..15h; control register at f9h.
// Notes:   Definitions only.
`ifndef LCD_SEGMENT_DRIVER_REGS_SVH
`define LCD_SEGMENT_DRIVER_REGS_SVH
`define LCD_CTRL_OFFSET      8'hf9
`define LCD_CTRL_RESET       8'h00
`define LCD_RAM_PAGE         4'h3
`define LCD_RAM_FIRST        8'h00
`define LCD_RAM_LAST         8'h15
`define LCD_SEG_COUNT        22
`define LCD_COM_COUNT        8
`define LCD_HIZ_BIT          7
`define LCD_CLKSEL_MSB       6
`define LCD_CLKSEL_LSB       4
`define LCD_DUTY_MSB         3
`define LCD_DUTY_LSB         1
`define LCD_ON_BIT           0
`define LCD_CLKSEL_MAX       3'h4
`define LCD_BASE_SHIFT       8
`define LCD_SHARED_FIRST     16
`define LCD_SHARED_LAST      19
`endif

// ==== design/lcd_segment_driver_pkg.sv ====
// Purpose: Types shared by the LCD segment driver files.
// Assumes: Bias level codes 0..4 name the ladder taps from ground to full drive.
// Notes:   Constants live in the register header.
package lcd_segment_driver_pkg;
  typedef logic [2:0] level_t;
  typedef enum logic [4:0] {
    DUTY_8 = 5'b00001,
    DUTY_4 = 5'b00010,
    DUTY_3A = 5'b00100,
    DUTY_3B = 5'b01000,
    DUTY_2 = 5'b10000
  } duty_e;
  typedef struct packed {
    logic       hiz;
    logic [2:0] clk_sel;
    logic [2:0] duty_sel;
    logic       on;
  } lcd_ctrl_s;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       bit_op;
    logic [2:0] bit_idx;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpu_req_s;
endpackage : lcd_segment_driver_pkg

// ==== design/lcd_frame_divider.sv ====
// Purpose: Divides the watch source clock strobe into the frame scan clock strobe.
// Assumes: watch_tick is a one-cycle pulse per watch source clock period.
// Notes:   A restart clears the prescaler.
`timescale 1ns/10ps
`include "lcd_segment_driver_regs.svh"
module lcd_frame_divider
  import lcd_segment_driver_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       restart,
  input  wire logic       watch_tick,
  input  wire logic [2:0] clk_sel,
  output logic            frame_tick
);
  logic [7:0] prescale;
  logic [3:0] shift;

  // Division is two to the power eight minus the select code; codes above 4 divide as code 4.
  always_comb begin
    if (clk_sel > `LCD_CLKSEL_MAX) begin
      shift = 4'd4;
    end else begin
      shift = 4'(`LCD_BASE_SHIFT) - {1'b0, clk_sel};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale   <= 8'h00;
      frame_tick <= 1'b0;
    end else if (restart) begin
      prescale   <= 8'h00;
      frame_tick <= 1'b0;
    end else if (watch_tick) begin
      prescale   <= prescale + 8'h01;
      frame_tick <= ((prescale + 8'h01) & 8'((9'h001 << shift) - 9'h001)) == 8'h00;
    end else begin
      frame_tick <= 1'b0;
    end
  end
endmodule : lcd_frame_divider

// ==== design/lcd_segment_driver.sv ====
// Purpose: Multiplexed LCD controller with display memory and one control register.
// Assumes: CPU strobes are synchronous to core_clk; levels feed an external bias ladder.
// Notes:   Each pin output is a 3-bit bias tap code; 0 is ground.
// Contract
// - Display memory page 3 locations 00h-15h.
// - Bit or byte access to display memory.
// - Location n feeds segment n, bit k common k.
// - Memory fetched autonomously on frame clock.
// - One selects, zero deselects each dot.
// - Segment data follows the active common.
// - Reset clears control register to zero.
// - Bits 6:4 select watch clock divider.
// - Bits 3:1 select duty and bias.
// - Selected clock sets common scan rate.
// - Control write restarts divider and duty.
// - Common count follows duty; shared pins switch.
// - Twenty-two segment outputs.
// - Display keeps running in idle modes.
`timescale 1ns/10ps
`include "lcd_segment_driver_regs.svh"
module lcd_segment_driver
  import lcd_segment_driver_pkg::*;
#(
  parameter int SEG_COUNT = `LCD_SEG_COUNT,
  parameter int COM_COUNT = `LCD_COM_COUNT
)(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire cpu_req_s               cpu_req,
  input  wire logic                   watch_tick,
  input  wire logic                   main_clk_stopped,
  output logic [7:0]                  cpu_rdata,
  output level_t [SEG_COUNT-1:0]      segment_drive_pins,
  output level_t [COM_COUNT-1:0]      common_drive_pins,
  output logic [COM_COUNT-1:0]        common_drive_oe,
  output lcd_ctrl_s                   lcd_display_control,
  output logic [2:0]                  active_common
);
  logic [7:0]   disp_ram [SEG_COUNT];
  logic [7:0]   fetch_ram [SEG_COUNT];
  logic         ram_hit;
  logic         ctrl_hit;
  logic         ctrl_wr;
  logic [4:0]   ram_idx;
  logic         frame_tick;
  logic [2:0]   phase;
  logic         polarity;
  logic [3:0]   com_num;
  logic [2:0]   top_level;
  logic [2:0]   half_level;
  duty_e        duty;
  logic [2:0]   next_phase;
  logic         next_polarity;

  assign ram_hit  = cpu_req.page == `LCD_RAM_PAGE && cpu_req.addr <= `LCD_RAM_LAST;
  assign ctrl_hit = cpu_req.addr == `LCD_CTRL_OFFSET && cpu_req.page != `LCD_RAM_PAGE;
  assign ctrl_wr  = cpu_req.wr && ctrl_hit;
  assign ram_idx  = cpu_req.addr[4:0];

  // Display memory: bit or byte writes; bits past the active commons keep any value.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SEG_COUNT; i++) begin
        disp_ram[i] <= 8'h00;
      end
    end else if (cpu_req.wr && ram_hit) begin
      if (cpu_req.bit_op) begin
        disp_ram[ram_idx][cpu_req.bit_idx] <= cpu_req.wdata[0];
      end else begin
        disp_ram[ram_idx] <= cpu_req.wdata;
      end
    end
  end

  // Control register.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lcd_display_control <= lcd_ctrl_s'(`LCD_CTRL_RESET);
    end else if (ctrl_wr) begin
      lcd_display_control <= lcd_ctrl_s'(cpu_req.wdata);
    end
  end

  // Read data.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_req.rd && ram_hit) begin
      cpu_rdata <= cpu_req.bit_op ? {7'h00, disp_ram[ram_idx][cpu_req.bit_idx]} : disp_ram[ram_idx];
    end else if (cpu_req.rd && ctrl_hit) begin
      cpu_rdata <= lcd_display_control;
    end else if (cpu_req.rd) begin
      cpu_rdata <= 8'h00;
    end
  end

  // Frame clock runs from the watch strobe only, so a stopped main clock domain does not halt it.
  lcd_frame_divider u_div (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .restart    (ctrl_wr),
    .watch_tick (watch_tick),
    .clk_sel    (lcd_display_control.clk_sel),
    .frame_tick (frame_tick)
  );

  always_comb begin
    case (lcd_display_control.duty_sel)
      3'b000: duty = DUTY_8;
      3'b001: duty = DUTY_4;
      3'b010: duty = DUTY_3A;
      3'b011: duty = DUTY_3B;
      default: duty = DUTY_2;
    endcase
  end

  always_comb begin
    case (duty)
      DUTY_8:  com_num = 4'd8;
      DUTY_4:  com_num = 4'd4;
      DUTY_3A: com_num = 4'd3;
      DUTY_3B: com_num = 4'd3;
      DUTY_2:  com_num = 4'd2;
      default: com_num = 4'd2;
    endcase
  end

  // Top tap: 4 at 1/4 bias, 3 at 1/3, 2 at 1/2; half is tap 1, the no-select step in from a rail.
  always_comb begin
    case (duty)
      DUTY_8:  top_level = 3'd4;
      DUTY_4:  top_level = 3'd3;
      DUTY_3A: top_level = 3'd3;
      default: top_level = 3'd2;
    endcase
    half_level = 3'd1;
  end

  always_comb begin
    next_phase    = phase + 3'd1;
    next_polarity = polarity;
    if ({1'b0, phase} >= com_num - 4'd1) begin
      next_phase    = 3'd0;
      next_polarity = ~polarity;
    end
  end

  // Common scan and snapshot of memory, autonomous and per frame clock.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase    <= 3'd0;
      polarity <= 1'b0;
      for (int i = 0; i < SEG_COUNT; i++) begin
        fetch_ram[i] <= 8'h00;
      end
    end else if (ctrl_wr) begin
      phase    <= 3'd0;
      polarity <= 1'b0;
    end else if (frame_tick) begin
      phase    <= next_phase;
      polarity <= next_polarity;
      for (int i = 0; i < SEG_COUNT; i++) begin
        fetch_ram[i] <= disp_ram[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_common <= 3'd0;
    end else begin
      active_common <= phase;
    end
  end

  // Segment waveforms: select takes the opposite rail to the common, no-select one tap in from the common's rail.
  genvar s;
  generate
    for (s = 0; s < SEG_COUNT; s++) begin : g_seg
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          segment_drive_pins[s] <= 3'd0;
        end else if (!lcd_display_control.on) begin
          segment_drive_pins[s] <= 3'd0;
        end else if (duty == DUTY_8 && s >= `LCD_SHARED_FIRST && s <= `LCD_SHARED_LAST) begin
          segment_drive_pins[s] <= 3'd0;
        end else if (fetch_ram[s][phase]) begin
          segment_drive_pins[s] <= polarity ? 3'd0 : top_level;
        end else begin
          segment_drive_pins[s] <= polarity ? (top_level - half_level) : half_level;
        end
      end
    end
  endgenerate

  // Common waveforms: active common at a rail, idle commons at the inner tap.
  genvar c;
  generate
    for (c = 0; c < COM_COUNT; c++) begin : g_com
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          common_drive_pins[c] <= 3'd0;
          common_drive_oe[c]   <= 1'b0;
        end else begin
          common_drive_oe[c] <= !lcd_display_control.hiz && (c < com_num);
          if (!lcd_display_control.on || c >= com_num) begin
            common_drive_pins[c] <= 3'd0;
          end else if (c == phase) begin
            common_drive_pins[c] <= polarity ? top_level : 3'd0;
          end else begin
            common_drive_pins[c] <= polarity ? (top_level - half_level) : half_level;
          end
        end
      end
    end
  endgenerate

  // Unused-input sink: main clock stop status does not gate the scan.
  logic unused_stop;
  assign unused_stop = main_clk_stopped;
endmodule : lcd_segment_driver

// ==== verif/lcd_segment_driver_chk.sv ====
// Purpose: Port assertions for the LCD segment driver.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to every instance of the driver.
`timescale 1ns/10ps
module lcd_segment_driver_chk
  import lcd_segment_driver_pkg::*;
#(
  parameter int SEG_COUNT = 22,
  parameter int COM_COUNT = 8
)(
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire cpu_req_s              cpu_req,
  input wire logic [7:0]            cpu_rdata,
  input wire level_t [SEG_COUNT-1:0] segment_drive_pins,
  input wire level_t [COM_COUNT-1:0] common_drive_pins,
  input wire logic [COM_COUNT-1:0]  common_drive_oe,
  input wire lcd_ctrl_s             lcd_display_control,
  input wire logic [2:0]            active_common
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence ctrl_wr;
    cpu_req.wr && cpu_req.addr == 8'hf9 && cpu_req.page != 4'h3;
  endsequence
  sequence quad_on;
    lcd_display_control.on && !lcd_display_control.hiz && lcd_display_control.duty_sel == 3'b001;
  endsequence
  off_low_a: assert property (!lcd_display_control.on [*3] |->
    segment_drive_pins == '0 && common_drive_pins == '0) else $error("Outputs not low while off.");
  hiz_oe_a: assert property (lcd_display_control.hiz [*2] |-> common_drive_oe == '0)
    else $error("Commons driven while floating.");
  restart_a: assert property (ctrl_wr |-> ##3 active_common == 3'h0)
    else $error("Scan not restarted by control write.");
  quad_range_a: assert property (lcd_display_control.duty_sel == 3'b001 [*3] |-> active_common <= 3'h3)
    else $error("Phase beyond four commons.");
  half_range_a: assert property (lcd_display_control.duty_sel[2] [*3] |-> active_common <= 3'h1)
    else $error("Phase beyond two commons.");
  quad_oe_a: assert property (quad_on [*3] |-> common_drive_oe == 8'h0f)
    else $error("Wrong commons enabled.");
  shared_seg_a: assert property ((lcd_display_control.on && lcd_display_control.duty_sel == 3'b000) [*3] |->
    segment_drive_pins[19:16] == '0) else $error("Shared pins drive segments.");
  unmapped_rd_a: assert property (cpu_req.rd && cpu_req.page == 4'h3 && cpu_req.addr > 8'h15 |=>
    cpu_rdata == 8'h00) else $error("Unmapped read not zero.");
  phase_hold_a: assert property ($changed(active_common) && active_common != 3'h0 |=>
    (!$changed(active_common) || active_common == 3'h0) [*8]) else $error("Phase stepped too fast.");
endmodule : lcd_segment_driver_chk
bind lcd_segment_driver lcd_segment_driver_chk #(.SEG_COUNT(SEG_COUNT), .COM_COUNT(COM_COUNT)) chk (
  .core_clk(core_clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
  .segment_drive_pins(segment_drive_pins), .common_drive_pins(common_drive_pins),
  .common_drive_oe(common_drive_oe), .lcd_display_control(lcd_display_control), .active_common(active_common));

// ==== verif/lcd_glass_model.sv ====
// Purpose: Glass panel model that reports which dots of one common row see full drive.
// Assumes: A dot lights when segment and common differ by the top tap.
// Notes:   The row is chosen by the bench.
`timescale 1ns/10ps
module lcd_glass_model
  import lcd_segment_driver_pkg::*;
#(
  parameter int SEGS = 22,
  parameter int COMS = 8
)(
  input  wire level_t [SEGS-1:0] seg,
  input  wire level_t [COMS-1:0] com,
  input  wire logic [COMS-1:0]   oe,
  input  wire logic [2:0]        row,
  input  wire level_t            top,
  output logic [SEGS-1:0]        lit
);
  always_comb begin
    for (int n = 0; n < SEGS; n++) begin
      lit[n] = oe[row] && ((seg[n] > com[row]) ? seg[n] - com[row] : com[row] - seg[n]) == top;
    end
  end
endmodule : lcd_glass_model

// ==== verif/test_lcd_segment_driver.sv ====
// Purpose: Self-checking bench for the LCD segment driver.
// Assumes: Watch tick pulses every second cycle.
// Notes:   Dots are judged through the glass model.
`timescale 1ns/10ps
module test_lcd_segment_driver
  import lcd_segment_driver_pkg::*;
;
  logic core_clk = 0, rst_n = 0, watch_tick = 0, main_clk_stopped = 0;
  cpu_req_s cpu_req = '0;
  logic [7:0] cpu_rdata, common_drive_oe;
  level_t [21:0] segment_drive_pins;
  level_t [7:0] common_drive_pins;
  lcd_ctrl_s lcd_display_control;
  logic [2:0] active_common;
  logic [21:0] lit;
  int failures = 0, check_count = 0;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) watch_tick <= #1 ~watch_tick;
  lcd_segment_driver DUT (.core_clk(core_clk), .rst_n(rst_n), .cpu_req(cpu_req), .watch_tick(watch_tick),
    .main_clk_stopped(main_clk_stopped), .cpu_rdata(cpu_rdata), .segment_drive_pins(segment_drive_pins),
    .common_drive_pins(common_drive_pins), .common_drive_oe(common_drive_oe),
    .lcd_display_control(lcd_display_control), .active_common(active_common));
  lcd_glass_model glass (.seg(segment_drive_pins), .com(common_drive_pins), .oe(common_drive_oe),
    .row(active_common), .top(3'h4), .lit(lit));
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic access(input logic w, input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d,
                        input logic b = 0, input logic [2:0] k = 0);
    @(posedge core_clk); #1;
    cpu_req = '{wr: w, rd: !w, bit_op: b, bit_idx: k, page: pg, addr: a, wdata: d};
    @(posedge core_clk); #1;
    cpu_req = '0;
    @(posedge core_clk); #1;
  endtask : access
  task automatic wait_change(output int n);
    logic [2:0] p;
    p = active_common;
    n = 0;
    while (active_common === p && n < 2000) begin
      @(posedge core_clk); #1;
      n++;
    end
    if (n >= 2000) failures++;
  endtask : wait_change
  task automatic t_ram;
    access(0, 4'h0, 8'hf9, 8'h00);
    check(cpu_rdata, 8'h00);
    check(segment_drive_pins, '0);
    access(1, 4'h3, 8'h15, 8'ha5);
    access(0, 4'h3, 8'h15, 8'h00);
    check(cpu_rdata, 8'ha5);
    access(1, 4'h3, 8'h02, 8'h01, 1, 3'h3);
    access(0, 4'h3, 8'h02, 8'h00);
    check(cpu_rdata, 8'h08);
    access(0, 4'h3, 8'h02, 8'h00, 1, 3'h3);
    check(cpu_rdata[0], 1'b1);
    access(1, 4'h3, 8'h16, 8'h5a);
    access(0, 4'h3, 8'h16, 8'h00);
    check(cpu_rdata, 8'h00);
  endtask : t_ram
  task automatic t_scan;
    int n;
    main_clk_stopped = 1;
    for (int s = 0; s < 22; s++) access(1, 4'h3, s[7:0], 8'h01 << (s % 8));
    access(1, 4'h0, 8'hf9, 8'h41);
    for (int i = 0; i < 8; i++) begin
      wait_change(n);
      repeat (2) @(posedge core_clk);
      #1;
      for (int s = 0; s < 22; s++) if (s < 16 || s > 19) check(lit[s], (s % 8) == active_common);
    end
  endtask : t_scan
  task automatic t_rate;
    int n;
    for (int c = 0; c < 6; c++) begin
      access(1, 4'h0, 8'hf9, {1'b0, c[2:0], 4'h1});
      wait_change(n);
      wait_change(n);
      check(n, 2 << (8 - ((c > 4) ? 4 : c)));
    end
  endtask : t_rate
  task automatic t_duty;
    logic [2:0] mx;
    int tops[5] = '{7, 3, 2, 2, 1};
    for (int d = 0; d < 5; d++) begin
      access(1, 4'h0, 8'hf9, {4'h4, d[2:0], 1'b1});
      mx = 0;
      repeat (300) begin
        @(posedge core_clk); #1;
        if (active_common > mx) mx = active_common;
      end
      check(mx, tops[d]);
      check(common_drive_oe, (2 << tops[d]) - 1);
    end
  endtask : t_duty
  task automatic t_modes;
    access(1, 4'h0, 8'hf9, 8'hc1);
    check(common_drive_oe, 8'h00);
    check(lcd_display_control, 8'hc1);
    access(1, 4'h0, 8'hf9, 8'h41);
    repeat (100) @(posedge core_clk);
    access(1, 4'h0, 8'hf9, 8'h41);
    check(active_common, 3'h0);
    access(1, 4'h0, 8'hf9, 8'h00);
    check({segment_drive_pins, common_drive_pins}, '0);
  endtask : t_modes
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin
    #2_000_000;
    failures++;
    results();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1;
    t_ram();
    t_scan();
    t_rate();
    t_duty();
    t_modes();
    results();
  end
endmodule : test_lcd_segment_driver
